/* File: hdl/masoc_map.vh */
// register map, field positions, reset values and timing for alarm control
`ifndef MASOC_MAP_VH
`define MASOC_MAP_VH

`define MASOC_OFF_STAT1        8'h01
`define MASOC_OFF_STAT2        8'h02
`define MASOC_OFF_MASK1        8'h03
`define MASOC_OFF_MASK2        8'h04
`define MASOC_OFF_FANPIN       8'h05
`define MASOC_OFF_OSCFG        8'h06

`define MASOC_RST_MASK1        8'h00
`define MASOC_RST_MASK2        8'h00
`define MASOC_RST_FANPIN       8'h14
`define MASOC_RST_OSCFG        3'h0

`define MASOC_ST2_HOT          0
`define MASOC_ST2_BTI          1
`define MASOC_ST2_FAN_A        2
`define MASOC_ST2_FAN_B        3
`define MASOC_ST2_CHASSIS      4
`define MASOC_ST2_OVERTEMP     5

`define MASOC_M2_INT_ONETIME   6
`define MASOC_M2_OS_ONETIME    7

`define MASOC_FP_MODE_A        0
`define MASOC_FP_MODE_B        1
`define MASOC_FP_CODE_A_HI     2
`define MASOC_FP_CODE_A_LO     3
`define MASOC_FP_CODE_B_HI     4
`define MASOC_FP_CODE_B_LO     5
`define MASOC_FP_OS_EN         6
`define MASOC_FP_RST_EN        7

`define MASOC_OC_PIN_STATE     0
`define MASOC_OC_OS_POL        1
`define MASOC_OC_OS_ONETIME    2
`define MASOC_OC_HIRES         3

`define MASOC_CODE_ACT_LOW     2'h1

`define MASOC_CLK_NS           100
`define MASOC_RST_PULSE_NS     10000
`define MASOC_RST_PULSE_CYC    16'h0064

`endif

/* File: hdl/masoc_alarm_ctrl.v */
// alarm status, masks, fan input modes and shared pin control with bus slave
`include "masoc_map.vh"

// Functional notes
// - hot limit sets status bit 0, mode-dependent
// - board alert input sets status bit 1
// - fan limits set status bits 2, 3
// - chassis intrusion high sets status bit 4
// - overtemp limit sets status bit 5, mode-dependent
// - mask 1 bits block status 1 interrupts
// - mask 2 bits 0-5 block status 2 interrupts
// - mask2 bit6 selects default or one-time
// - mask2 bit7 selects comparator or one-time
// - fan mode bit selects level or count
// - count mode divides by 1,2,4,8
// - level mode code 01 low, 00 high
// - bit6 only selects overtemp pin function
// - bit7 only selects reset pin function
// - both bits set disables shared pin
// - config bit0 reads pin state in overtemp function, else 0
// - config bit1 sets overtemp polarity
// - config bit2 one-time or comparator pin
// - config bit3 selects high resolution
// - low temperature bits read in 7:4 in high resolution, else only bit 7
// - status read returns then clears, drops interrupt
// - one-time rearms only below hysteresis
// - comparator holds until below hysteresis
// - interrupt needs interrupt enable bit
module masoc_alarm_ctrl #(
  parameter [6:0]  DEV_ADDR      = 7'h2f,
  parameter [15:0] RST_PULSE_CYC = `MASOC_RST_PULSE_CYC
) (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe,
  input  wire       board_temp_alert_input_n,
  input  wire       chassis_intrusion_input,
  input  wire       fan_input_a,
  input  wire       fan_input_b,
  input  wire       hot_limit_exceeded,
  input  wire       hot_below_hyst,
  input  wire       os_limit_exceeded,
  input  wire       os_below_hyst,
  input  wire [1:0] fan_over_limit,
  input  wire [7:0] status_first,
  input  wire       int_enable,
  input  wire       int_clear,
  input  wire       reset_out_req,
  input  wire [3:0] temp_low_bits,
  output reg        status_first_clr,
  output reg        interrupt_out,
  output reg        shared_reset_overtemp_pin,
  output reg        shared_pin_oe,
  output reg        reset_out_done,
  output reg        high_resolution,
  output reg  [1:0] fan_count_pulse,
  output reg  [1:0] fan_level_active
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_PTR  = 3'h2;
  localparam [2:0] ST_WR   = 3'h3;
  localparam [2:0] ST_RD   = 3'h4;

  // pin synchronisers: scl, sda, alert, chassis, fan a, fan b
  reg  [5:0] sync1_r;
  reg  [5:0] sync2_r;
  reg  [5:0] sync3_r;
  wire       scl_s  = sync2_r[0];
  wire       sda_s  = sync2_r[1];
  wire       scl_q  = sync3_r[0];
  wire       sda_q  = sync3_r[1];

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // idle level of each pin, so no false event follows reset
      sync1_r <= 6'h07;
      sync2_r <= 6'h07;
      sync3_r <= 6'h07;
    end else begin
      sync1_r <= {fan_input_b, fan_input_a, chassis_intrusion_input,
                  board_temp_alert_input_n, sda_in, scl_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;

  // two-wire slave
  reg  [2:0] st_r;
  reg  [3:0] bcnt_r;
  reg  [7:0] shf_r;
  reg  [7:0] ptr_r;
  reg        ack_r;
  reg        rw_r;
  reg        mnack_r;
  reg  [7:0] rdata;

  wire active  = ~bus_start & ~bus_stop & (st_r != ST_IDLE);
  wire wr_now  = active & scl_fall & ~ack_r & (bcnt_r == 4'h8) &
                 (st_r == ST_WR);
  wire rd_load = active & scl_fall & ack_r &
                 (((st_r == ST_ADDR) & rw_r) | ((st_r == ST_RD) & ~mnack_r));
  wire clr2    = rd_load & (ptr_r == `MASOC_OFF_STAT2);

  assign sda_out = 1'b0;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r    <= ST_IDLE;
      bcnt_r  <= 4'h0;
      shf_r   <= 8'h00;
      ptr_r   <= 8'h00;
      ack_r   <= 1'b0;
      rw_r    <= 1'b0;
      mnack_r <= 1'b1;
      sda_oe  <= 1'b0;
    end else if (bus_start) begin
      st_r   <= ST_ADDR;
      bcnt_r <= 4'h0;
      ack_r  <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st_r   <= ST_IDLE;
      ack_r  <= 1'b0;
      sda_oe <= 1'b0;
    end else if (st_r != ST_IDLE) begin
      if (scl_rise && !ack_r && st_r != ST_RD) begin
        shf_r  <= {shf_r[6:0], sda_s};
        bcnt_r <= bcnt_r + 4'h1;
      end
      if (scl_rise && ack_r && st_r == ST_RD) begin
        mnack_r <= sda_s;
      end
      if (scl_fall) begin
        if (ack_r) begin
          ack_r  <= 1'b0;
          sda_oe <= 1'b0;
          bcnt_r <= 4'h0;
          if (rd_load) begin
            st_r   <= ST_RD;
            shf_r  <= rdata;
            sda_oe <= ~rdata[7];
            bcnt_r <= 4'h1;
          end else if (st_r == ST_RD || (st_r == ST_ADDR && rw_r)) begin
            st_r <= ST_IDLE;
          end else if (st_r == ST_ADDR) begin
            st_r <= ST_PTR;
          end else begin
            st_r <= ST_WR;
          end
        end else if (bcnt_r == 4'h8) begin
          if (st_r == ST_RD) begin
            sda_oe <= 1'b0;
            ack_r  <= 1'b1;
            ptr_r  <= ptr_r + 8'h01;
          end else if (st_r == ST_ADDR) begin
            if (shf_r[7:1] == DEV_ADDR) begin
              ack_r  <= 1'b1;
              sda_oe <= 1'b1;
              rw_r   <= shf_r[0];
            end else begin
              st_r <= ST_IDLE;
            end
          end else begin
            if (st_r == ST_PTR) begin
              ptr_r <= shf_r;
            end else begin
              ptr_r <= ptr_r + 8'h01;
            end
            ack_r  <= 1'b1;
            sda_oe <= 1'b1;
          end
        end else if (st_r == ST_RD) begin
          shf_r  <= {shf_r[6:0], 1'b0};
          sda_oe <= ~shf_r[6];
          bcnt_r <= bcnt_r + 4'h1;
        end
      end
    end
  end

  // registers
  reg  [5:0] stat2_r;
  reg  [7:0] mask1_r;
  reg  [7:0] mask2_r;
  reg  [7:0] fanpin_r;
  reg  [3:1] oscfg_r;
  reg        hot_armed_r;
  reg        os_armed_r;
  reg        pin_armed_r;
  reg        os_act_r;
  reg        rst_act_r;
  reg [15:0] rst_cnt_r;
  reg  [5:0] stat2_set;
  reg  [5:0] stat2_nxt;

  wire hot_onetime = mask2_r[`MASOC_M2_INT_ONETIME];
  wire os_onetime  = mask2_r[`MASOC_M2_OS_ONETIME];
  wire hot_evt = hot_limit_exceeded & (~hot_onetime | hot_armed_r);
  wire os_evt  = os_limit_exceeded & (~os_onetime | os_armed_r);
  wire pin_os  = fanpin_r[`MASOC_FP_OS_EN] & ~fanpin_r[`MASOC_FP_RST_EN];
  wire pin_rst = fanpin_r[`MASOC_FP_RST_EN] & ~fanpin_r[`MASOC_FP_OS_EN];
  wire pin_ot  = oscfg_r[`MASOC_OC_OS_ONETIME];

  always @* begin
    stat2_set = 6'h00;
    stat2_set[`MASOC_ST2_HOT]      = hot_evt;
    stat2_set[`MASOC_ST2_BTI]      = ~sync2_r[2];
    stat2_set[`MASOC_ST2_FAN_A]    = fan_over_limit[0];
    stat2_set[`MASOC_ST2_FAN_B]    = fan_over_limit[1];
    stat2_set[`MASOC_ST2_CHASSIS]  = sync2_r[3];
    stat2_set[`MASOC_ST2_OVERTEMP] = os_evt;
    stat2_nxt = (clr2 ? 6'h00 : stat2_r) | stat2_set;
  end

  always @* begin
    rdata = 8'h00;
    case (ptr_r)
      `MASOC_OFF_STAT2:  rdata = {2'b00, stat2_r};
      `MASOC_OFF_MASK1:  rdata = mask1_r;
      `MASOC_OFF_MASK2:  rdata = mask2_r;
      `MASOC_OFF_FANPIN: rdata = fanpin_r;
      `MASOC_OFF_OSCFG: begin
        rdata[`MASOC_OC_PIN_STATE] = pin_os & shared_reset_overtemp_pin;
        rdata[3:1] = oscfg_r;
        if (oscfg_r[`MASOC_OC_HIRES]) begin
          rdata[7:4] = temp_low_bits;
        end else begin
          rdata[7] = temp_low_bits[3];
        end
      end
      default:           rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stat2_r          <= 6'h00;
      mask1_r          <= `MASOC_RST_MASK1;
      mask2_r          <= `MASOC_RST_MASK2;
      fanpin_r         <= `MASOC_RST_FANPIN;
      oscfg_r          <= `MASOC_RST_OSCFG;
      status_first_clr <= 1'b0;
      high_resolution  <= 1'b0;
    end else begin
      stat2_r          <= stat2_nxt;
      status_first_clr <= rd_load & (ptr_r == `MASOC_OFF_STAT1);
      high_resolution  <= oscfg_r[`MASOC_OC_HIRES];
      if (wr_now) begin
        case (ptr_r)
          `MASOC_OFF_MASK1:  mask1_r  <= shf_r;
          `MASOC_OFF_MASK2:  mask2_r  <= shf_r;
          `MASOC_OFF_FANPIN: fanpin_r <= shf_r;
          `MASOC_OFF_OSCFG:  oscfg_r  <= shf_r[3:1];
          default:           mask1_r  <= mask1_r;
        endcase
      end
    end
  end

  // rearm flags and over-temperature pin state
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hot_armed_r <= 1'b1;
      os_armed_r  <= 1'b1;
      pin_armed_r <= 1'b1;
      os_act_r    <= 1'b0;
    end else begin
      if (!hot_onetime || hot_below_hyst) begin
        hot_armed_r <= 1'b1;
      end else if (hot_evt) begin
        hot_armed_r <= 1'b0;
      end
      if (!os_onetime || os_below_hyst) begin
        os_armed_r <= 1'b1;
      end else if (os_evt) begin
        os_armed_r <= 1'b0;
      end
      if (!pin_ot) begin
        pin_armed_r <= 1'b1;
        if (os_limit_exceeded) begin
          os_act_r <= 1'b1;
        end else if (os_below_hyst) begin
          os_act_r <= 1'b0;
        end
      end else begin
        if (os_limit_exceeded && pin_armed_r) begin
          os_act_r    <= 1'b1;
          pin_armed_r <= 1'b0;
        end else begin
          if (clr2) begin
            os_act_r <= 1'b0;
          end
          if (os_below_hyst) begin
            pin_armed_r <= 1'b1;
          end
        end
      end
    end
  end

  // interrupt output and shared pin drive
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      interrupt_out             <= 1'b0;
      rst_act_r                 <= 1'b0;
      rst_cnt_r                 <= 16'h0000;
      reset_out_done            <= 1'b0;
      shared_reset_overtemp_pin <= 1'b1;
      shared_pin_oe             <= 1'b0;
    end else begin
      interrupt_out <= int_enable & ~int_clear &
                       ((|(stat2_r & ~mask2_r[5:0])) |
                        (|(status_first & ~mask1_r)));
      reset_out_done <= 1'b0;
      if (rst_act_r) begin
        if (rst_cnt_r == RST_PULSE_CYC - 16'h0001) begin
          rst_act_r      <= 1'b0;
          reset_out_done <= 1'b1;
        end
        rst_cnt_r <= rst_cnt_r + 16'h0001;
      end else if (reset_out_req && pin_rst) begin
        rst_act_r <= 1'b1;
        rst_cnt_r <= 16'h0000;
      end
      shared_pin_oe <= pin_os | pin_rst;
      if (pin_os) begin
        shared_reset_overtemp_pin <= oscfg_r[`MASOC_OC_OS_POL] ?
                                     os_act_r : ~os_act_r;
      end else begin
        shared_reset_overtemp_pin <= ~(pin_rst & rst_act_r);
      end
    end
  end

  // fan inputs: divided pulse count or level sense
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_fan
      reg  [2:0] div_cnt_r;
      wire       mode_lvl = fanpin_r[`MASOC_FP_MODE_A + g];
      wire [1:0] code     = {fanpin_r[`MASOC_FP_CODE_A_HI + 2 * g],
                             fanpin_r[`MASOC_FP_CODE_A_LO + 2 * g]};
      wire [2:0] div_top  = (code == 2'h0) ? 3'h0 :
                            (code == 2'h1) ? 3'h1 :
                            (code == 2'h2) ? 3'h3 : 3'h7;
      wire       pin_s    = sync2_r[4 + g];
      wire       pin_rise = pin_s & ~sync3_r[4 + g];

      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          div_cnt_r           <= 3'h0;
          fan_count_pulse[g]  <= 1'b0;
          fan_level_active[g] <= 1'b0;
        end else begin
          fan_count_pulse[g] <= 1'b0;
          if (mode_lvl) begin
            div_cnt_r           <= 3'h0;
            fan_level_active[g] <= (code == `MASOC_CODE_ACT_LOW) ?
                                   ~pin_s : pin_s;
          end else begin
            fan_level_active[g] <= 1'b0;
            if (pin_rise) begin
              if (div_cnt_r >= div_top) begin
                div_cnt_r          <= 3'h0;
                fan_count_pulse[g] <= 1'b1;
              end else begin
                div_cnt_r <= div_cnt_r + 3'h1;
              end
            end
          end
        end
      end
    end
  endgenerate

endmodule // masoc_alarm_ctrl

/* File: verification/masoc_alarm_ctrl_asserts.sv */
// port assertions for the alarm control block
module masoc_alarm_ctrl_asserts #(
  parameter [15:0] RST_PULSE_CYC = 16'h0064
) (
  input wire       clk_sys,
  input wire       rstn,
  input wire       scl_in,
  input wire       sda_oe,
  input wire       int_enable,
  input wire       int_clear,
  input wire       status_first_clr,
  input wire       interrupt_out,
  input wire       shared_reset_overtemp_pin,
  input wire       shared_pin_oe,
  input wire       reset_out_done,
  input wire [1:0] fan_count_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] low_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // cycles in a row that the shared pin is driven low
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      low_r <= 16'h0000;
    else if (shared_pin_oe && !shared_reset_overtemp_pin)
      low_r <= low_r + 16'h0001;
    else
      low_r <= 16'h0000;
  end

  property p_int_en;
    !int_enable |=> !interrupt_out;
  endproperty
  a_int_en: assert property (p_int_en)
    else $error("interrupt while disabled");
  property p_int_clr;
    int_clear |=> !interrupt_out;
  endproperty
  a_int_clr: assert property (p_int_clr)
    else $error("interrupt while clear bit set");
  property p_pin_idle;
    !shared_pin_oe |-> shared_reset_overtemp_pin;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("undriven pin not idle");
  property p_rst_len;
    $rose(shared_reset_overtemp_pin) && $past(reset_out_done)
      |-> low_r == RST_PULSE_CYC;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset pulse length wrong");
  property p_done;
    reset_out_done |=> !reset_out_done && shared_reset_overtemp_pin;
  endproperty
  a_done: assert property (p_done)
    else $error("reset done not a pulse");
  property p_fan_pulse;
    fan_count_pulse[0] |=> !fan_count_pulse[0];
  endproperty
  a_fan_pulse: assert property (p_fan_pulse)
    else $error("fan pulse too long");
  property p_clr;
    status_first_clr |=> !status_first_clr;
  endproperty
  a_clr: assert property (p_clr)
    else $error("status clear not a pulse");
  property p_sda;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 3);
  endproperty
  a_sda: assert property (p_sda)
    else $error("data line changed out of clock low");
endmodule // masoc_alarm_ctrl_asserts

bind masoc_alarm_ctrl masoc_alarm_ctrl_asserts #(
  .RST_PULSE_CYC(RST_PULSE_CYC)
) u_chk (
  .clk_sys                   (clk_sys),
  .rstn                      (rstn),
  .scl_in                    (scl_in),
  .sda_oe                    (sda_oe),
  .int_enable                (int_enable),
  .int_clear                 (int_clear),
  .status_first_clr          (status_first_clr),
  .interrupt_out             (interrupt_out),
  .shared_reset_overtemp_pin (shared_reset_overtemp_pin),
  .shared_pin_oe             (shared_pin_oe),
  .reset_out_done            (reset_out_done),
  .fan_count_pulse           (fan_count_pulse)
);

/* File: verification/masoc_host.sv */
// two-wire bus master standing in for the host processor
module masoc_host #(
  parameter [6:0] ADDR = 7'h2f
) (
  input  wire  clk,
  input  wire  sda,
  output logic scl,
  output logic pull
);
  timeunit 1ns;
  timeprecision 1ns;
  int q = 5;

  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic bx(input logic b, output logic r);
    pull = !b;
    w(q);
    scl = 1'b1;
    w(2 * q);
    r = sda;
    scl = 1'b0;
    w(q);
  endtask

  task automatic xfer(input [8:0] b, output [8:0] r);
    for (int i = 8; i >= 0; i--)
      bx(b[i], r[i]);
  endtask

  task automatic start;
    pull = 1'b0;
    w(q);
    scl = 1'b1;
    w(2 * q);
    pull = 1'b1;
    w(2 * q);
    scl = 1'b0;
    w(q);
  endtask

  task automatic stop;
    pull = 1'b1;
    w(q);
    scl = 1'b1;
    w(2 * q);
    pull = 1'b0;
    w(2 * q);
  endtask

  task automatic wr(input [7:0] a, input [7:0] d);
    logic [8:0] r;
    start();
    xfer({ADDR, 2'b01}, r);
    xfer({a, 1'b1}, r);
    xfer({d, 1'b1}, r);
    stop();
  endtask

  // last bit released: the master refuses more data
  task automatic rd(input [7:0] a, output [7:0] d);
    logic [8:0] r;
    start();
    xfer({ADDR, 2'b01}, r);
    xfer({a, 1'b1}, r);
    start();
    xfer({ADDR, 2'b11}, r);
    xfer(9'h1ff, r);
    d = r[8:1];
    stop();
  endtask
endmodule // masoc_host

/* File: verification/tb_top.sv */
// self-checking bench for the alarm control block
`define CHK(n, e, a) \
  begin \
    num_checks++; \
    if ((a) !== (e)) begin \
      err_count++; \
      $display("MISMATCH %s exp %h got %h", n, e, a); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys, rstn, int_enable, int_clear;
  logic       board_temp_alert_input_n, chassis_intrusion_input;
  logic       fan_input_a, fan_input_b, reset_out_req;
  logic       hot_limit_exceeded, hot_below_hyst;
  logic       os_limit_exceeded, os_below_hyst;
  logic [1:0] fan_over_limit;
  logic [7:0] status_first;
  logic [3:0] temp_low_bits;
  wire        scl_in, sda_in, sda_out, sda_oe, pull, status_first_clr;
  wire        interrupt_out, shared_reset_overtemp_pin, shared_pin_oe;
  wire        reset_out_done, high_resolution;
  wire  [1:0] fan_count_pulse, fan_level_active;
  int         err_count = 0, num_checks = 0, pulses = 0, lowcnt = 0;
  int         clrs = 0, pulses_b = 0, k;
  logic [7:0] d;

  masoc_alarm_ctrl #(.RST_PULSE_CYC(16'h0004)) uut (
    .clk_sys                   (clk_sys),
    .rstn                      (rstn),
    .scl_in                    (scl_in),
    .sda_in                    (sda_in),
    .sda_out                   (sda_out),
    .sda_oe                    (sda_oe),
    .board_temp_alert_input_n  (board_temp_alert_input_n),
    .chassis_intrusion_input   (chassis_intrusion_input),
    .fan_input_a               (fan_input_a),
    .fan_input_b               (fan_input_b),
    .hot_limit_exceeded        (hot_limit_exceeded),
    .hot_below_hyst            (hot_below_hyst),
    .os_limit_exceeded         (os_limit_exceeded),
    .os_below_hyst             (os_below_hyst),
    .fan_over_limit            (fan_over_limit),
    .status_first              (status_first),
    .int_enable                (int_enable),
    .int_clear                 (int_clear),
    .reset_out_req             (reset_out_req),
    .temp_low_bits             (temp_low_bits),
    .status_first_clr          (status_first_clr),
    .interrupt_out             (interrupt_out),
    .shared_reset_overtemp_pin (shared_reset_overtemp_pin),
    .shared_pin_oe             (shared_pin_oe),
    .reset_out_done            (reset_out_done),
    .high_resolution           (high_resolution),
    .fan_count_pulse           (fan_count_pulse),
    .fan_level_active          (fan_level_active)
  );
  masoc_host host (.clk(clk_sys), .sda(sda_in), .scl(scl_in), .pull(pull));
  assign sda_in = !(sda_oe || pull);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = !clk_sys;
  end

  always @(posedge clk_sys) begin
    if (fan_count_pulse[0]) pulses++;
    if (fan_count_pulse[1]) pulses_b++;
    if (shared_pin_oe && !shared_reset_overtemp_pin) lowcnt++;
    if (status_first_clr) clrs++;
  end

  task automatic final_report;
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic rc(input [7:0] a, input [7:0] e, input string n);
    logic [7:0] v;
    host.rd(a, v);
    `CHK(n, e, v)
  endtask

  task automatic cause(input int i, input logic v);
    case (i)
      0: hot_limit_exceeded = v;
      1: board_temp_alert_input_n = !v;
      2: fan_over_limit[0] = v;
      3: fan_over_limit[1] = v;
      4: chassis_intrusion_input = v;
      default: os_limit_exceeded = v;
    endcase
  endtask

  task automatic os_set(input logic lim, input logic hy);
    os_limit_exceeded = lim;
    os_below_hyst = hy;
    host.w(4);
  endtask

  initial begin
    #8_000_000;
    err_count++;
    final_report();
  end

  initial begin
    rstn = 1'b0;
    int_enable = 1'b0;
    int_clear = 1'b0;
    board_temp_alert_input_n = 1'b1;
    chassis_intrusion_input = 1'b0;
    fan_input_a = 1'b0;
    fan_input_b = 1'b0;
    hot_limit_exceeded = 1'b0;
    hot_below_hyst = 1'b1;
    os_limit_exceeded = 1'b0;
    os_below_hyst = 1'b1;
    reset_out_req = 1'b0;
    fan_over_limit = 2'b00;
    status_first = 8'h00;
    temp_low_bits = 4'h0;
    repeat (20) @(posedge clk_sys);
    #1 rstn = 1'b1;
    host.q = 8;
    host.w(4);
    rc(8'h03, 8'h00, "mask1");
    rc(8'h04, 8'h00, "mask2");
    rc(8'h05, 8'h14, "fanpin");
    rc(8'h06, 8'h00, "oscfg");
    rc(8'h3f, 8'h00, "unmapped");
    host.q = 5;
    int_enable = 1'b1;
    for (int i = 0; i < 6; i++) begin
      cause(i, 1'b1);
      host.w(4);
      cause(i, 1'b0);
      host.w(4);
      `CHK("irq", 1'b1, interrupt_out)
      rc(8'h02, 8'h01 << i, "status2");
      `CHK("irq_clr", 1'b0, interrupt_out)
    end
    host.wr(8'h04, 8'h3f);
    for (int i = 0; i < 6; i++) cause(i, 1'b1);
    host.w(4);
    for (int i = 0; i < 6; i++) cause(i, 1'b0);
    host.w(4);
    `CHK("irq_masked", 1'b0, interrupt_out)
    rc(8'h02, 8'h3f, "status2_masked");
    host.wr(8'h04, 8'h40);
    hot_below_hyst = 1'b0;
    hot_limit_exceeded = 1'b1;
    host.w(4);
    rc(8'h02, 8'h01, "hot_once");
    rc(8'h02, 8'h00, "hot_no_recur");
    hot_limit_exceeded = 1'b0;
    hot_below_hyst = 1'b1;
    host.w(4);
    hot_limit_exceeded = 1'b1;
    host.w(4);
    `CHK("irq_rearm", 1'b1, interrupt_out)
    hot_limit_exceeded = 1'b0;
    rc(8'h02, 8'h01, "hot_rearm");
    status_first = 8'h80;
    host.w(3);
    `CHK("irq_st1", 1'b1, interrupt_out)
    int_clear = 1'b1;
    host.w(3);
    `CHK("irq_held", 1'b0, interrupt_out)
    int_clear = 1'b0;
    host.wr(8'h03, 8'h80);
    `CHK("irq_mask1", 1'b0, interrupt_out)
    host.rd(8'h01, d);
    `CHK("st1_clr", 1, clrs)
    status_first = 8'h00;
    host.wr(8'h05, 8'h40);
    os_set(1'b1, 1'b0);
    `CHK("os_oe", 1'b1, shared_pin_oe)
    `CHK("os_low", 1'b0, shared_reset_overtemp_pin)
    rc(8'h06, 8'h00, "os_state");
    os_set(1'b0, 1'b0);
    `CHK("os_hold", 1'b0, shared_reset_overtemp_pin)
    os_set(1'b0, 1'b1);
    `CHK("os_free", 1'b1, shared_reset_overtemp_pin)
    rc(8'h06, 8'h01, "os_state_hi");
    host.wr(8'h06, 8'h06);
    os_set(1'b1, 1'b0);
    `CHK("os_high", 1'b1, shared_reset_overtemp_pin)
    os_set(1'b0, 1'b1);
    `CHK("os_once", 1'b1, shared_reset_overtemp_pin)
    rc(8'h02, 8'h20, "os_status");
    `CHK("os_rel", 1'b0, shared_reset_overtemp_pin)
    host.wr(8'h04, 8'h80);
    os_set(1'b1, 1'b0);
    rc(8'h02, 8'h20, "os_st_once");
    rc(8'h02, 8'h00, "os_st_no_recur");
    os_set(1'b0, 1'b1);
    host.wr(8'h05, 8'hc0);
    `CHK("pin_off", 1'b0, shared_pin_oe)
    host.wr(8'h05, 8'h80);
    lowcnt = 0;
    reset_out_req = 1'b1;
    for (k = 0; k < 40 && reset_out_done !== 1'b1; k++) host.w(1);
    reset_out_req = 1'b0;
    host.w(1);
    `CHK("rst_len", 4, lowcnt)
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h05, {2'b00, c[0], c[1], c[0], c[1], 2'b00});
      pulses = 0;
      pulses_b = 0;
      repeat (8) begin
        fan_input_a = 1'b1;
        fan_input_b = 1'b1;
        host.w(3);
        fan_input_a = 1'b0;
        fan_input_b = 1'b0;
        host.w(3);
      end
      host.w(4);
      `CHK("fan_div", 8 >> c, pulses)
      `CHK("fan_div_b", 8 >> c, pulses_b)
    end
    host.wr(8'h05, 8'h0b);
    `CHK("lvl_low", 1'b1, fan_level_active[0])
    `CHK("lvl_b_high", 1'b0, fan_level_active[1])
    host.wr(8'h05, 8'h23);
    fan_input_a = 1'b1;
    host.w(4);
    `CHK("lvl_high", 1'b1, fan_level_active[0])
    `CHK("lvl_b_low", 1'b1, fan_level_active[1])
    fan_input_a = 1'b0;
    temp_low_bits = 4'ha;
    host.wr(8'h06, 8'h08);
    `CHK("hires", 1'b1, high_resolution)
    rc(8'h06, 8'ha8, "temp_hi");
    host.wr(8'h06, 8'hf0);
    rc(8'h06, 8'h80, "temp_lo");
    final_report();
  end
endmodule // tb_top
